// ### hdl/ewc_pkg.sv
package ewc_pkg;
    // cache geometry
    localparam int CACHE_BYTES = 64;
    localparam int PAGE_BYTES = 8;
    localparam int CACHE_PAGES = 8;
    localparam int ADDR_W = 13;
    localparam int PTR_W = 6;
    localparam int OFS_W = 3;
    localparam int PAGE_W = ADDR_W - OFS_W;
    // control byte layout
    localparam logic [3:0] CTRL_CODE = 4'ha;
    localparam int CTRL_CODE_LSB = 4;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_RW_BIT = 0;
    localparam int ADDR_HI_BITS = ADDR_W - 8;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // write cycle timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PAGE_WRITE_MS = 5;
    localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_MS * 1000000 / CLK_PERIOD_NS;
    // buffer
    localparam int BUF_DEPTH = 2;
    localparam logic SYNC_RST = 1'b1;
endpackage : ewc_pkg

// ### hdl/ewc_buf.sv
`timescale 1ns/10ps
`default_nettype none
module ewc_buf #(
    parameter int WIDTH = 21,
    parameter int DEPTH = ewc_pkg::BUF_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH != 2 ** AW || WIDTH < 1)
            $error("ewc_buf: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end
endmodule : ewc_buf
`default_nettype wire

// ### hdl/ewc_pager.sv
// Behaviour
// R1: first data byte of each write goes into cache page 0
// R2: start slot in page 0 equals the three lowest address bits
// R3: a full cache wraps its last bytes into page 0 empty slots
// R4: bytes beyond cache capacity keep wrapping and overwrite older bytes
// R5: on stop, page 0 goes to addressed page, then consecutive pages
// R6: one full timed write cycle per committed page, one after another
// R7: only loaded bytes of a partial page reach the array
// R8: standby once stop seen and all page writes finished
// R9: standby also after aborted transfers once activity ends
// R10: array writes blocked while supply monitor reports low voltage; bytes already in the buffer still reach the array
// R11: respond only when control select bits match the strapped pins
// R12: data line changes only while the clock line is low
// R13: data line only pulled low or released, never driven high
// R14: cache holds sixty-four bytes as eight pages of eight
// R15: no acknowledge or action while a write cycle runs
// R16: each page cycle lasts at most 5 ms, partial pages alike
// R17: page cycle length is a parameterised count of clock cycles
`timescale 1ns/10ps
`default_nettype none
module ewc_pager #(
    parameter int PAGE_CYCLES = ewc_pkg::PAGE_WRITE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic chip_select_bit0,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit2,
    input wire logic vdd_low_in,
    output logic arr_valid_out,
    input wire logic arr_ready_in,
    output logic [ewc_pkg::ADDR_W-1:0] arr_addr_out,
    output logic [7:0] arr_data_out,
    output logic busy_out,
    output logic standby_out
);
    localparam int TW = $clog2(PAGE_CYCLES + 1);
    localparam int BW = ewc_pkg::ADDR_W + 8;

    initial
    begin
        if (PAGE_CYCLES < 1 || PAGE_CYCLES > ewc_pkg::PAGE_WRITE_CYCLES)
            $error("ewc_pager: PAGE_CYCLES out of range"); // see R16
    end

    // =========================================================
    // pin synchronisers
    // =========================================================
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_s;
    logic sda_s;
    logic [2:0] sel_s;
    logic vdd_low_s;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_q <= 6'h03;
            sync2_q <= 6'h03;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q <= {vdd_low_in, chip_select_bit2, chip_select_bit1,
                        chip_select_bit0, sda_in, scl_in};
            sync2_q <= sync1_q;
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_s = sync2_q[0];
    assign sda_s = sync2_q[1];
    assign sel_s = sync2_q[4:2];
    assign vdd_low_s = sync2_q[5];

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // =========================================================
    // bus receiver
    // =========================================================
    typedef enum logic [2:0] {
        ewc_b_idle, ewc_b_ctrl, ewc_b_addr_hi, ewc_b_addr_lo, ewc_b_data,
        ewc_b_skip
    } ewc_bus_t;

    typedef enum logic [1:0] {ewc_c_idle, ewc_c_push, ewc_c_wait} ewc_com_t;

    ewc_bus_t bus_q;
    ewc_com_t com_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic ack_q;
    logic [ewc_pkg::ADDR_W-1:0] addr_q;
    logic [ewc_pkg::PTR_W-1:0] ptr_q;
    logic [7:0] cache_q [ewc_pkg::CACHE_BYTES];
    logic [ewc_pkg::CACHE_BYTES-1:0] loaded_q;
    logic [7:0] byte_in;
    logic ctrl_hit;
    logic byte_done;
    logic busy;

    assign byte_in = shift_q;
    assign byte_done = scl_fall && (bit_q == ewc_pkg::BIT_ACK);
    assign busy = (com_q != ewc_c_idle);
    assign ctrl_hit = !busy && byte_in[ewc_pkg::CTRL_RW_BIT] == 1'b0
        && byte_in[ewc_pkg::CTRL_SEL_LSB +: 3] == sel_s
        && byte_in[ewc_pkg::CTRL_CODE_LSB +: 4]
        == ewc_pkg::CTRL_CODE; // see R11 R15

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bit_q <= '0;
            shift_q <= '0;
        end
        else if (start_det || stop_det)
            bit_q <= '0;
        else if (scl_rise)
        begin
            if (bit_q == ewc_pkg::BIT_ACK)
                bit_q <= '0;
            else
            begin
                shift_q <= {shift_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
            end
        end
    end

    // ack driven from one scl fall to the next
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            ack_q <= 1'b0;
        else if (start_det || stop_det)
            ack_q <= 1'b0;
        else if (scl_fall) // see R12
        begin
            if (byte_done)
            begin
                unique case (bus_q)
                    ewc_b_ctrl: ack_q <= ctrl_hit;
                    ewc_b_addr_hi, ewc_b_addr_lo, ewc_b_data: ack_q <= 1'b1;
                    ewc_b_idle, ewc_b_skip: ack_q <= 1'b0;
                endcase
            end
            else
                ack_q <= 1'b0;
        end
    end

    assign sda_out = 1'b0; // see R13
    assign sda_oe_n_out = !ack_q; // see R13

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            bus_q <= ewc_b_idle;
        else if (start_det)
            bus_q <= ewc_b_ctrl; // see R9
        else if (stop_det)
            bus_q <= ewc_b_idle;
        else if (byte_done)
        begin
            unique case (bus_q)
                ewc_b_ctrl: bus_q <= ctrl_hit ? ewc_b_addr_hi : ewc_b_skip;
                ewc_b_addr_hi: bus_q <= ewc_b_addr_lo;
                ewc_b_addr_lo: bus_q <= ewc_b_data;
                ewc_b_data: bus_q <= ewc_b_data;
                ewc_b_idle, ewc_b_skip: bus_q <= ewc_b_skip;
            endcase
        end
    end

    // =========================================================
    // cache load
    // =========================================================
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_q <= '0;
            ptr_q <= '0;
        end
        else if (byte_done && bus_q == ewc_b_addr_hi)
            addr_q[ewc_pkg::ADDR_W-1:8] <= byte_in[ewc_pkg::ADDR_HI_BITS-1:0];
        else if (byte_done && bus_q == ewc_b_addr_lo)
        begin
            addr_q[7:0] <= byte_in;
            ptr_q <= {3'h0, byte_in[ewc_pkg::OFS_W-1:0]}; // see R1 R2
        end
        else if (byte_done && bus_q == ewc_b_data)
            ptr_q <= ptr_q + 6'h01; // see R3 R4
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (byte_done && bus_q == ewc_b_data)
            cache_q[ptr_q] <= byte_in; // see R4 R14
    end

    logic [2:0] page_q;
    logic [2:0] slot_q;
    logic [TW-1:0] timer_q;
    logic page_end;
    logic more_pages;
    logic [ewc_pkg::PTR_W-1:0] rd_idx;
    logic buf_ready;
    logic push_ok;

    assign rd_idx = {page_q, slot_q};
    assign more_pages = (page_q != 3'h7) && (|loaded_q[{page_q + 3'h1, 3'h0} +:
                        ewc_pkg::PAGE_BYTES]);
    assign page_end = (com_q == ewc_c_wait) && (timer_q == '0);
    assign push_ok = !loaded_q[rd_idx] || vdd_low_s || buf_ready; // see R10

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            loaded_q <= '0;
        else if (byte_done && bus_q == ewc_b_addr_lo)
            loaded_q <= '0;
        else if (byte_done && bus_q == ewc_b_data)
            loaded_q[ptr_q] <= 1'b1;
        else if (com_q == ewc_c_idle && stop_det && bus_q != ewc_b_data)
            loaded_q <= '0;
        else if (page_end && !more_pages)
            loaded_q <= '0;
    end

    // =========================================================
    // commit engine
    // =========================================================
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            com_q <= ewc_c_idle;
            page_q <= '0;
            slot_q <= '0;
            timer_q <= '0;
        end
        else
        begin
            unique case (com_q)
                ewc_c_idle:
                begin
                    page_q <= '0;
                    slot_q <= '0;
                    if (stop_det && bus_q == ewc_b_data && |loaded_q)
                        com_q <= ewc_c_push; // see R5 R8
                end
                ewc_c_push:
                begin
                    if (push_ok)
                    begin
                        slot_q <= slot_q + 3'h1;
                        if (slot_q == 3'h7)
                        begin
                            com_q <= ewc_c_wait;
                            timer_q <= TW'(PAGE_CYCLES - 1); // see R16 R17
                        end
                    end
                end
                ewc_c_wait:
                begin
                    if (timer_q != '0)
                        timer_q <= timer_q - 1'b1; // see R6
                    else if (more_pages)
                    begin
                        page_q <= page_q + 3'h1; // see R5 R6
                        com_q <= ewc_c_push;
                    end
                    else
                        com_q <= ewc_c_idle;
                end
            endcase
        end
    end

    logic [BW-1:0] buf_in;
    logic [BW-1:0] buf_out;
    logic buf_valid;
    logic [ewc_pkg::PAGE_W-1:0] arr_page;

    assign arr_page = addr_q[ewc_pkg::ADDR_W-1:ewc_pkg::OFS_W]
                      + ewc_pkg::PAGE_W'(page_q); // see R5
    assign buf_in = {arr_page, slot_q, cache_q[rd_idx]};
    assign buf_valid = (com_q == ewc_c_push) && loaded_q[rd_idx]
                       && !vdd_low_s; // see R7 R10

    ewc_buf #(
        .WIDTH(BW),
        .DEPTH(ewc_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .in_valid_in(buf_valid),
        .in_ready_out(buf_ready),
        .in_data_in(buf_in),
        .out_valid_out(arr_valid_out),
        .out_ready_in(arr_ready_in),
        .out_data_out(buf_out)
    );

    assign arr_addr_out = buf_out[BW-1:8];
    assign arr_data_out = buf_out[7:0];
    assign busy_out = busy; // see R15
    assign standby_out = !busy && !arr_valid_out
                         && (bus_q == ewc_b_idle); // see R8 R9
endmodule : ewc_pager
`default_nettype wire

// ### verif/ewc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// pager checker
module ewc_mon #(
    parameter int PAGE_CYCLES = 16
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic vdd_low_in,
    input wire logic arr_ready_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic arr_valid_out,
    input wire logic [ewc_pkg::ADDR_W-1:0] arr_addr_out,
    input wire logic [7:0] arr_data_out,
    input wire logic busy_out,
    input wire logic standby_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    int busy_cnt_q;
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            busy_cnt_q <= 0;
        else if (!busy_out)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
    end
    property p_drain; !sda_out; endproperty
    a_drain: assert property (p_drain)
        else $error("sda value high");
    property p_oe; $changed(sda_oe_n_out) |-> !scl_in; endproperty
    a_oe: assert property (p_oe)
        else $error("sda moved with scl high");
    property p_nak; busy_out |-> sda_oe_n_out; endproperty
    a_nak: assert property (p_nak)
        else $error("ack while busy");
    property p_stby; busy_out |-> !standby_out; endproperty
    a_stby: assert property (p_stby)
        else $error("standby while busy");
    property p_quiet;
        standby_out |-> sda_oe_n_out && !arr_valid_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("activity in standby");
    property p_hold;
        arr_valid_out && !arr_ready_in |=> arr_valid_out
            && $stable(arr_addr_out) && $stable(arr_data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("array word lost");
    property p_lowv;
        $rose(busy_out) && vdd_low_in && $past(vdd_low_in, 4)
            |-> !arr_valid_out [*8];
    endproperty
    a_lowv: assert property (p_lowv)
        else $error("write at low supply");
    property p_page; $fell(busy_out) |-> busy_cnt_q >= PAGE_CYCLES; endproperty
    a_page: assert property (p_page)
        else $error("page cycle short");
endmodule : ewc_mon
bind ewc_pager ewc_mon #(.PAGE_CYCLES(PAGE_CYCLES)) ewc_mon_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
    .vdd_low_in(vdd_low_in), .arr_ready_in(arr_ready_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .arr_valid_out(arr_valid_out),
    .arr_addr_out(arr_addr_out), .arr_data_out(arr_data_out),
    .busy_out(busy_out), .standby_out(standby_out));
`default_nettype wire

// ### verif/ewc_bm.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// bus master, 1 on sda_out releases the line
module ewc_bm (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        repeat (8) @(posedge clk_sys_in);
        #1;
        scl_out = c;
        sda_out = d;
    endtask : step
    task automatic bus_start();
        step(scl_out, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : bus_start
    task automatic bus_stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : bus_stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
            step(1'b0, b[i]);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        repeat (6) @(posedge clk_sys_in);
        ack = (sda_in === 1'b0);
        step(1'b0, 1'b1);
    endtask : send_byte
endmodule : ewc_bm
`default_nettype wire

// ### verif/eeprom_write_cache_pager_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// pager bench
module eeprom_write_cache_pager_tb_top;
    localparam int PC = 400;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic vdd_low = 1'b0;
    logic arr_ready = 1'b1;
    logic stall = 1'b0;
    logic [2:0] pins = 3'h5;
    wire logic scl, m_sda, sda_o, sda_oe_n, arr_valid, busy, standby;
    wire logic [ewc_pkg::ADDR_W-1:0] arr_addr;
    wire logic [7:0] arr_data;
    // pull-up on the shared data line
    wire logic sda = m_sda & (sda_oe_n | sda_o);
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int busy_n = 0;
    int npg = 0;
    logic [20:0] got_q[$];
    logic [20:0] exp_q[$];
    ewc_bm ewc_bm_i (.clk_sys_in(clk_sys_in), .sda_in(sda),
        .scl_out(scl), .sda_out(m_sda));
    ewc_pager #(.PAGE_CYCLES(PC)) ewc_pager_i (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_n_out(sda_oe_n), .chip_select_bit0(pins[0]),
        .chip_select_bit1(pins[1]), .chip_select_bit2(pins[2]),
        .vdd_low_in(vdd_low), .arr_valid_out(arr_valid),
        .arr_ready_in(arr_ready), .arr_addr_out(arr_addr),
        .arr_data_out(arr_data), .busy_out(busy), .standby_out(standby));
    always #4 clk_sys_in = ~clk_sys_in;
    // sample settled outputs mid-cycle; a transfer here lands at next rise
    always @(negedge clk_sys_in)
    begin
        if (arr_valid === 1'b1 && arr_ready === 1'b1)
            got_q.push_back({arr_addr, arr_data});
        busy_n += int'(busy === 1'b1);
    end
    always @(posedge clk_sys_in)
    begin
        if (cyc == 60000)
        begin
            n_errors++;
            report_and_stop();
        end
        cyc <= cyc + 1;
        #1 arr_ready = !stall || cyc[1];
    end
    task automatic cmp(input string nm, input logic [20:0] e,
        input logic [20:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic expect_wr(input logic [12:0] a, input int n);
        logic [7:0] img [64];
        bit ld [64];
        int p;
        exp_q.delete();
        got_q.delete();
        busy_n = 0;
        npg = 0;
        foreach (ld[j])
            ld[j] = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            p = (int'(a[2:0]) + i) % ewc_pkg::CACHE_BYTES;
            img[p] = 8'(i + 64);
            ld[p] = 1'b1;
        end
        for (int j = 0; j < ewc_pkg::CACHE_BYTES; j++)
            if (ld[j])
            begin
                exp_q.push_back({a[12:3] + 10'(j / 8), 3'(j % 8), img[j]});
                npg = j / 8 + 1;
            end
    endtask : expect_wr
    task automatic wr(input logic [2:0] sel, input logic [12:0] a,
        input int n, input logic stop, output logic ack);
        logic k;
        ewc_bm_i.bus_start();
        ewc_bm_i.send_byte({ewc_pkg::CTRL_CODE, sel, 1'b0}, ack);
        if (ack)
        begin
            ewc_bm_i.send_byte({3'h0, a[12:8]}, k);
            ewc_bm_i.send_byte(a[7:0], k);
            for (int i = 0; i < n; i++)
                ewc_bm_i.send_byte(8'(i + 64), k);
        end
        if (stop)
            ewc_bm_i.bus_stop();
    endtask : wr
    task automatic finish_wr(input string nm);
        logic ok;
        for (int t = 0; t < 6000; t++)
        begin
            @(posedge clk_sys_in);
            if (t > 20 && standby === 1'b1)
                break;
        end
        #1;
        ok = busy_n >= npg * PC && busy_n <= npg * (PC + 20) + 8;
        cmp({nm, " standby"}, 21'(1), 21'(standby));
        cmp({nm, " busy time"}, 21'(1), 21'(ok));
        cmp({nm, " count"}, 21'(exp_q.size()), 21'(got_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size())
                cmp(nm, exp_q[i], got_q[i]);
    endtask : finish_wr
    task automatic t_pages();
        logic k;
        expect_wr(13'h001a, 3);
        wr(pins, 13'h001a, 3, 1'b1, k);
        cmp("ack", 21'(1), 21'(k));
        finish_wr("offset");
        expect_wr(13'h1ffe, 12);
        wr(pins, 13'h1ffe, 12, 1'b1, k);
        finish_wr("cross");
        $display("test pages done");
    endtask : t_pages
    task automatic t_over();
        logic k;
        stall = 1'b1;
        expect_wr(13'h0032, 66);
        wr(pins, 13'h0032, 66, 1'b1, k);
        finish_wr("overflow");
        stall = 1'b0;
        $display("test overflow done");
    endtask : t_over
    task automatic t_refuse();
        logic k;
        for (int i = 0; i < 3; i++)
        begin
            expect_wr(13'h0100, 0);
            wr(pins ^ 3'(1 << i), 13'h0100, 2, 1'b1, k);
            cmp("wrong select", 21'(0), 21'(k));
            finish_wr("wrong select");
        end
        pins = 3'h2;
        expect_wr(13'h0208, 1);
        wr(pins, 13'h0208, 1, 1'b1, k);
        wr(pins, 13'h0000, 0, 1'b1, k);
        cmp("busy ack", 21'(0), 21'(k));
        finish_wr("busy");
        expect_wr(13'h0300, 0);
        wr(pins, 13'h0300, 2, 1'b0, k);
        wr(pins, 13'h0300, 0, 1'b1, k);
        finish_wr("abort");
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_lowv();
        logic k;
        vdd_low = 1'b1;
        expect_wr(13'h0040, 2);
        exp_q.delete();
        wr(pins, 13'h0040, 2, 1'b1, k);
        finish_wr("low supply");
        vdd_low = 1'b0;
        $display("test low supply done");
    endtask : t_lowv
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        #1;
        cmp("reset standby", 21'(1), 21'(standby));
        t_pages();
        t_over();
        t_refuse();
        t_lowv();
        report_and_stop();
    end
endmodule : eeprom_write_cache_pager_tb_top
`default_nettype wire
